// ### logic/dtb_pkg.sv
// shared constants, types and field layouts of the data transfer and bit execution unit
package dtb_pkg;

    // ****************************************************************
    // sizes, indices and reset values
    // ****************************************************************
    localparam int GPR_COUNT = 32;
    localparam logic [7:0] GPR_RESET = 8'h00;
    localparam logic [4:0] GPR_R0_IDX = 5'h00;
    localparam logic [4:0] GPR_R1_IDX = 5'h01;
    localparam int Z_LO_IDX = 30;
    localparam int Z_HI_IDX = 31;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // ****************************************************************
    // status flag positions
    // ****************************************************************
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_T = 3'h6;

    // ****************************************************************
    // software register map
    // ****************************************************************
    localparam logic [7:0] REG_GPR_LIMIT = 8'h20;
    localparam logic [7:0] REG_STATUS_FLAGS = 8'h20;
    localparam logic [7:0] REG_STACK_PTR_LO = 8'h21;
    localparam logic [7:0] REG_STACK_PTR_HI = 8'h22;
    localparam logic [7:0] REG_UNIT_STATE = 8'h23;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [4:0] {
        OP_PROGRAM_MEM_READ_INC,
        OP_PROGRAM_MEM_WRITE,
        OP_PORT_IN,
        OP_PORT_OUT,
        OP_STACK_PUSH,
        OP_STACK_POP,
        OP_IO_BIT_SET,
        OP_IO_BIT_CLEAR,
        OP_SHIFT_LEFT_LOGICAL,
        OP_SHIFT_RIGHT_LOGICAL,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_SHIFT_RIGHT_ARITH,
        OP_NIBBLE_SWAP,
        OP_STATUS_BIT_SET,
        OP_STATUS_BIT_CLEAR,
        OP_BIT_TO_FLAG_STORE
    } dtb_op_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PM_FETCH,
        ST_PM_TAKE,
        ST_PM_STORE,
        ST_IO_MODIFY,
        ST_STACK_PUSH,
        ST_STACK_POP
    } dtb_state_t;

    typedef struct packed {
        dtb_op_t op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [5:0] io_addr;
        logic [2:0] bit_sel;
    } dtb_cmd_t;

    typedef struct packed {
        logic z;
        logic c;
        logic n;
        logic v;
    } dtb_shift_flags_t;

    typedef struct packed {
        logic rd;
        logic we;
        logic [14:0] addr;
        logic [15:0] wdata;
    } dtb_pm_req_t;

    typedef struct packed {
        logic we;
        logic [5:0] addr;
        logic [7:0] wdata;
    } dtb_io_req_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
    } dtb_st_req_t;

endpackage : dtb_pkg

// ### logic/dtb_shift_unit.sv
// single register shift, rotate and nibble swap with flag results
`timescale 1ns/1ps
module dtb_shift_unit
    import dtb_pkg::*;
(
    input dtb_op_t op,
    input logic [7:0] operand,
    input logic carry_in,
    output logic [7:0] result,
    output dtb_shift_flags_t flags,
    output logic flags_upd
);

    always_comb begin
        result = operand;
        flags.c = 1'b0;
        flags_upd = 1'b1;
        case (op)
            OP_SHIFT_LEFT_LOGICAL: begin
                result = {operand[6:0], 1'b0};
                flags.c = operand[7];
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
                result = {1'b0, operand[7:1]};
                flags.c = operand[0];
            end
            OP_ROTATE_LEFT_CARRY: begin
                result = {operand[6:0], carry_in};
                flags.c = operand[7];
            end
            OP_ROTATE_RIGHT_CARRY: begin
                result = {carry_in, operand[7:1]};
                flags.c = operand[0];
            end
            OP_SHIFT_RIGHT_ARITH: begin
                result = {operand[7], operand[7:1]};
                flags.c = operand[0];
            end
            OP_NIBBLE_SWAP: begin
                result = {operand[3:0], operand[7:4]};
                flags_upd = 1'b0;
            end
            default: begin
                flags_upd = 1'b0;
            end
        endcase
        flags.z = (result == 8'h00);
        flags.n = result[7];
        flags.v = flags.n ^ flags.c;
    end

endmodule : dtb_shift_unit

// ### logic/dtb_exec.sv
// execution unit for program memory, port, stack, bit and shift instructions
`timescale 1ns/1ps
// ****************************************************************
// What this block does
// - program memory read loads byte at pointer, bumps pointer, three cycles, flags kept
// - program memory write stores r1:r0 word at pointer, flags kept
// - port input copies selected I/O register into destination in one cycle
// - port output writes source register to selected I/O register in one cycle
// - push places source register on stack in two cycles, flags kept
// - pop loads top stack byte into destination in two cycles, flags kept
// - I/O bit set forces one bit to one, others kept, two cycles
// - I/O bit clear forces one bit to zero, others kept, two cycles
// - left shift moves bits up, zero into bit zero, one cycle, flags
// - right shift moves bits down, zero into bit seven, flags updated
// - rotate left puts old carry in bit zero, bit seven to carry
// - rotate right puts old carry in bit seven, bit zero to carry
// - arithmetic right shift keeps bit seven, one cycle, flags updated
// - nibble swap exchanges halves in one cycle, no flag touched
// - flag set raises only the selected status bit in one cycle
// - flag clear lowers only the selected status bit in one cycle
// - bit store copies chosen source bit into transfer flag only
// ****************************************************************
module dtb_exec
    import dtb_pkg::*;
(
    input logic clk_sys,
    input logic sys_rst,
    // instruction issue
    input logic cmd_valid,
    input dtb_cmd_t cmd,
    output logic cmd_ready,
    output logic done,
    // software register port
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_we,
    input logic reg_re,
    output logic [7:0] reg_rdata,
    // program memory, read data one cycle after the strobe
    output dtb_pm_req_t pm_req,
    input logic [15:0] pm_rdata,
    // I/O register space, read is combinational
    output logic [5:0] io_raddr,
    input logic [7:0] io_rdata,
    output dtb_io_req_t io_req,
    // data stack, read data in the strobe cycle
    output dtb_st_req_t st_req,
    input logic [7:0] st_rdata
);

    // ****************************************************************
    // state
    // ****************************************************************
    dtb_state_t state_r;
    dtb_state_t state_nxt;
    dtb_cmd_t cmd_r;
    logic [7:0] gpr_r [0:GPR_COUNT-1];
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [15:0] sp_r;
    logic pm_byte_hi_r;
    logic done_r;
    dtb_pm_req_t pm_req_r;
    dtb_io_req_t io_req_r;
    dtb_st_req_t st_req_r;
    logic [7:0] reg_rdata_r;

    logic issue;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [15:0] z_val;
    logic [15:0] z_next;
    logic [7:0] io_in_val;
    logic [7:0] bit_mask;
    logic gpr_we;
    logic [4:0] gpr_waddr;
    logic [7:0] gpr_wdata;
    logic z_inc;
    logic bus_gpr_we;
    logic [7:0] sh_result;
    dtb_shift_flags_t sh_flags;
    logic sh_flags_upd;

    assign cmd_ready = (state_r == ST_IDLE);
    assign issue = cmd_valid && cmd_ready;
    assign rd_val = gpr_r[cmd.rd];
    assign rr_val = gpr_r[cmd.rr];
    assign z_val = {gpr_r[Z_HI_IDX], gpr_r[Z_LO_IDX]};
    assign z_next = z_val + ONE16;
    assign bit_mask = 8'h01 << cmd.bit_sel;
    assign bus_gpr_we = reg_we && (reg_addr < REG_GPR_LIMIT);
    assign io_raddr = cmd.io_addr;
    // a write still standing on the port has not landed yet, so forward it
    assign io_in_val = (io_req_r.we && io_req_r.addr == cmd.io_addr) ? io_req_r.wdata : io_rdata;

    assign pm_req = pm_req_r;
    assign io_req = io_req_r;
    assign st_req = st_req_r;
    assign reg_rdata = reg_rdata_r;
    assign done = done_r;

    dtb_shift_unit u_shift (
        .op(cmd.op),
        .operand(rd_val),
        .carry_in(flags_r[FLAG_C]),
        .result(sh_result),
        .flags(sh_flags),
        .flags_upd(sh_flags_upd)
    );

    // ****************************************************************
    // sequencing
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (issue) begin
                    case (cmd.op)
                        OP_PROGRAM_MEM_READ_INC: state_nxt = ST_PM_FETCH;
                        OP_PROGRAM_MEM_WRITE: state_nxt = ST_PM_STORE;
                        OP_IO_BIT_SET: state_nxt = ST_IO_MODIFY;
                        OP_IO_BIT_CLEAR: state_nxt = ST_IO_MODIFY;
                        OP_STACK_PUSH: state_nxt = ST_STACK_PUSH;
                        OP_STACK_POP: state_nxt = ST_STACK_POP;
                        default: state_nxt = ST_IDLE;
                    endcase
                end
            end
            ST_PM_FETCH: state_nxt = ST_PM_TAKE;
            ST_PM_TAKE: state_nxt = ST_IDLE;
            ST_PM_STORE: state_nxt = ST_IDLE;
            ST_IO_MODIFY: state_nxt = ST_IDLE;
            ST_STACK_PUSH: state_nxt = ST_IDLE;
            ST_STACK_POP: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cmd_r <= '0;
            pm_byte_hi_r <= 1'b0;
        end else if (issue) begin
            cmd_r <= cmd;
            pm_byte_hi_r <= z_val[0];
        end
    end

    // the last cycle of every instruction is flagged one cycle later
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            done_r <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            done_r <= issue && (state_nxt == ST_IDLE);
        end else begin
            done_r <= (state_nxt == ST_IDLE);
        end
    end

    // ****************************************************************
    // outside requests, strobes last one cycle
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pm_req_r <= '0;
        end else begin
            pm_req_r.rd <= issue && cmd.op == OP_PROGRAM_MEM_READ_INC;
            pm_req_r.we <= issue && cmd.op == OP_PROGRAM_MEM_WRITE;
            if (issue) begin
                pm_req_r.addr <= z_val[15:1];
                pm_req_r.wdata <= {gpr_r[GPR_R1_IDX], gpr_r[GPR_R0_IDX]};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            io_req_r <= '0;
        end else begin
            io_req_r.we <= 1'b0;
            if (issue) begin
                io_req_r.addr <= cmd.io_addr;
                case (cmd.op)
                    OP_PORT_OUT: begin
                        io_req_r.we <= 1'b1;
                        io_req_r.wdata <= rr_val;
                    end
                    OP_IO_BIT_SET: begin
                        io_req_r.we <= 1'b1;
                        io_req_r.wdata <= io_in_val | bit_mask;
                    end
                    OP_IO_BIT_CLEAR: begin
                        io_req_r.we <= 1'b1;
                        io_req_r.wdata <= io_in_val & ~bit_mask;
                    end
                    default: io_req_r.we <= 1'b0;
                endcase
            end
        end
    end

    // stack grows downward: push stores then decrements, pop increments then loads
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_req_r <= '0;
        end else begin
            st_req_r.we <= issue && cmd.op == OP_STACK_PUSH;
            st_req_r.re <= issue && cmd.op == OP_STACK_POP;
            if (issue && cmd.op == OP_STACK_PUSH) begin
                st_req_r.addr <= sp_r;
                st_req_r.wdata <= rr_val;
            end else if (issue && cmd.op == OP_STACK_POP) begin
                st_req_r.addr <= sp_r + ONE16;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sp_r <= SP_RESET;
        end else if (issue && cmd.op == OP_STACK_PUSH) begin
            sp_r <= sp_r - ONE16;
        end else if (issue && cmd.op == OP_STACK_POP) begin
            sp_r <= sp_r + ONE16;
        end else if (reg_we && reg_addr == REG_STACK_PTR_LO) begin
            sp_r[7:0] <= reg_wdata;
        end else if (reg_we && reg_addr == REG_STACK_PTR_HI) begin
            sp_r[15:8] <= reg_wdata;
        end
    end

    // ****************************************************************
    // register file write back
    // ****************************************************************
    always_comb begin
        gpr_we = 1'b0;
        gpr_waddr = cmd.rd;
        gpr_wdata = sh_result;
        z_inc = 1'b0;
        if (issue && cmd.op == OP_PORT_IN) begin
            gpr_we = 1'b1;
            gpr_wdata = io_in_val;
        end else if (issue && (cmd.op == OP_NIBBLE_SWAP || sh_flags_upd)) begin
            gpr_we = 1'b1;
        end else if (state_r == ST_PM_TAKE) begin
            gpr_we = 1'b1;
            gpr_waddr = cmd_r.rd;
            gpr_wdata = pm_byte_hi_r ? pm_rdata[15:8] : pm_rdata[7:0];
            z_inc = 1'b1;
        end else if (state_r == ST_STACK_POP) begin
            gpr_we = 1'b1;
            gpr_waddr = cmd_r.rd;
            gpr_wdata = st_rdata;
        end
    end

    // instruction results win over a software write to the same entry
    for (genvar gi = 0; gi < GPR_COUNT; gi++) begin : g_gpr
        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                gpr_r[gi] <= GPR_RESET;
            end else if (gpr_we && gpr_waddr == 5'(gi)) begin
                gpr_r[gi] <= gpr_wdata;
            end else if (z_inc && gi == Z_LO_IDX) begin
                gpr_r[gi] <= z_next[7:0];
            end else if (z_inc && gi == Z_HI_IDX) begin
                gpr_r[gi] <= z_next[15:8];
            end else if (bus_gpr_we && reg_addr[4:0] == 5'(gi)) begin
                gpr_r[gi] <= reg_wdata;
            end
        end
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    always_comb begin
        flags_nxt = (reg_we && reg_addr == REG_STATUS_FLAGS) ? reg_wdata : flags_r;
        if (issue) begin
            case (cmd.op)
                OP_STATUS_BIT_SET: flags_nxt[cmd.bit_sel] = 1'b1;
                OP_STATUS_BIT_CLEAR: flags_nxt[cmd.bit_sel] = 1'b0;
                OP_BIT_TO_FLAG_STORE: flags_nxt[FLAG_T] = rr_val[cmd.bit_sel];
                default: begin
                    if (sh_flags_upd) begin
                        flags_nxt[FLAG_Z] = sh_flags.z;
                        flags_nxt[FLAG_C] = sh_flags.c;
                        flags_nxt[FLAG_N] = sh_flags.n;
                        flags_nxt[FLAG_V] = sh_flags.v;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flags_r <= FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ****************************************************************
    // software read port
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_re) begin
            if (reg_addr < REG_GPR_LIMIT) begin
                reg_rdata_r <= gpr_r[reg_addr[4:0]];
            end else if (reg_addr == REG_STATUS_FLAGS) begin
                reg_rdata_r <= flags_r;
            end else if (reg_addr == REG_STACK_PTR_LO) begin
                reg_rdata_r <= sp_r[7:0];
            end else if (reg_addr == REG_STACK_PTR_HI) begin
                reg_rdata_r <= sp_r[15:8];
            end else if (reg_addr == REG_UNIT_STATE) begin
                reg_rdata_r <= {7'h00, ~cmd_ready};
            end else begin
                reg_rdata_r <= 8'h00;
            end
        end else begin
            reg_rdata_r <= 8'h00;
        end
    end

endmodule : dtb_exec

// ### tb/dtb_mem_model.sv
// program memory, data stack and I/O space behind the execution unit
`timescale 1ns/1ps
module dtb_mem_model
    import dtb_pkg::*;
(
    input logic clk_sys,
    input dtb_pm_req_t pm_req,
    output logic [15:0] pm_rdata,
    input logic [5:0] io_raddr,
    output logic [7:0] io_rdata,
    input dtb_io_req_t io_req,
    input dtb_st_req_t st_req,
    output logic [7:0] st_rdata
);
    logic [15:0] pm_mem [256];
    logic [7:0] io_mem [64];
    logic [7:0] st_mem [256];
    logic [7:0] junk_r = 8'h5a;
    initial pm_rdata = 16'h0000;
    // outside its one valid cycle the word toggles so stale data cannot pass
    always @(posedge clk_sys) begin
        pm_rdata <= pm_req.rd ? pm_mem[pm_req.addr[7:0]] : ~pm_rdata;
        junk_r <= ~junk_r;
        if (pm_req.we) pm_mem[pm_req.addr[7:0]] <= pm_req.wdata;
        if (io_req.we) io_mem[io_req.addr] <= io_req.wdata;
        if (st_req.we) st_mem[st_req.addr[7:0]] <= st_req.wdata;
    end
    assign io_rdata = io_mem[io_raddr];
    assign st_rdata = st_req.re ? st_mem[st_req.addr[7:0]] : junk_r;
endmodule : dtb_mem_model

// ### tb/dtb_exec_asserts.sv
// concurrent checks on the execution unit ports
`timescale 1ns/1ps
module dtb_exec_asserts
    import dtb_pkg::*;
(
    input logic clk_sys,
    input logic sys_rst,
    input logic cmd_valid,
    input dtb_cmd_t cmd,
    input logic cmd_ready,
    input logic done,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_we,
    input logic reg_re,
    input logic [7:0] reg_rdata,
    input dtb_pm_req_t pm_req,
    input logic [15:0] pm_rdata,
    input logic [5:0] io_raddr,
    input logic [7:0] io_rdata,
    input dtb_io_req_t io_req,
    input dtb_st_req_t st_req,
    input logic [7:0] st_rdata
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    logic take;
    logic fwd;
    assign take = cmd_valid && cmd_ready;
    // a write still in flight to the same port is forwarded, not read
    assign fwd = io_req.we && io_req.addr == cmd.io_addr;
    one_cycle_a: assert property (take && (cmd.op inside {OP_PORT_IN, OP_PORT_OUT} ||
        cmd.op >= OP_SHIFT_LEFT_LOGICAL) |=> done && cmd_ready) else $error("one cycle op late");
    two_cycle_a: assert property (take && cmd.op inside {OP_PROGRAM_MEM_WRITE,
        OP_STACK_PUSH, OP_STACK_POP, OP_IO_BIT_SET, OP_IO_BIT_CLEAR}
        |=> !cmd_ready && !done ##1 done && cmd_ready) else $error("two cycle op timing");
    pm_read_a: assert property (take && cmd.op == OP_PROGRAM_MEM_READ_INC
        |=> pm_req.rd && !cmd_ready ##1 !pm_req.rd && !cmd_ready ##1 done)
        else $error("program read timing");
    port_out_a: assert property (take && cmd.op == OP_PORT_OUT
        |=> io_req.we && io_req.addr == $past(cmd.io_addr)) else $error("port write missing");
    bit_set_a: assert property (take && cmd.op == OP_IO_BIT_SET && !fwd
        |=> io_req.we && io_req.wdata == ($past(io_rdata) | (8'h01 << $past(cmd.bit_sel))))
        else $error("io bit set value");
    bit_clear_a: assert property (take && cmd.op == OP_IO_BIT_CLEAR && !fwd
        |=> io_req.we && io_req.wdata == ($past(io_rdata) & ~(8'h01 << $past(cmd.bit_sel))))
        else $error("io bit clear value");
    push_strobe_a: assert property (take && cmd.op == OP_STACK_PUSH
        |=> st_req.we && !st_req.re ##1 !st_req.we) else $error("push strobe");
    pop_strobe_a: assert property (take && cmd.op == OP_STACK_POP
        |=> st_req.re && !st_req.we ##1 !st_req.re) else $error("pop strobe");
    idle_quiet_a: assert property (cmd_ready && !cmd_valid
        |=> !(pm_req.rd || pm_req.we || io_req.we || st_req.we || st_req.re))
        else $error("strobe without request");
endmodule : dtb_exec_asserts

// ### tb/tb.sv
// self-checking bench for the execution unit against a reference model
`timescale 1ns/1ps
module tb
    import dtb_pkg::*;
;
    logic clk_sys, sys_rst, cmd_valid, reg_we, reg_re, cmd_ready, done;
    dtb_cmd_t cmd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, io_rdata, st_rdata;
    logic [15:0] pm_rdata;
    logic [5:0] io_raddr;
    dtb_pm_req_t pm_req;
    dtb_io_req_t io_req;
    dtb_st_req_t st_req;
    int fail_count, checks_done, flg, sp, iov;
    int gpr [32];

    dtb_exec u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .done(done), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pm_req(pm_req),
        .pm_rdata(pm_rdata), .io_raddr(io_raddr), .io_rdata(io_rdata), .io_req(io_req),
        .st_req(st_req), .st_rdata(st_rdata));
    dtb_mem_model u_mem (.clk_sys(clk_sys), .pm_req(pm_req), .pm_rdata(pm_rdata),
        .io_raddr(io_raddr), .io_rdata(io_rdata), .io_req(io_req), .st_req(st_req),
        .st_rdata(st_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // bus and compare tasks
    // ****************************************************************
    task automatic tally_and_finish;
        if (fail_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_we <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input int exp);
        @(posedge clk_sys);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        #1;
        cmp(16'(reg_rdata), 16'(exp & 255));
    endtask : reg_rd

    task automatic setr(input int a, input int v);
        gpr[a] = v & 255;
        reg_wr(8'(a), 8'(v));
    endtask : setr

    task automatic chk(input int a);
        reg_rd(8'(a), gpr[a]);
    endtask : chk

    // counts cycles from the taking edge to done
    task automatic issue(input dtb_op_t op, input int rd, rr, io, b, ncyc);
        int n;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd <= {op, 5'(rd), 5'(rr), 6'(io), 3'(b)};
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        n = 1;
        #1;
        while (done !== 1'b1 && n < 8) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        cmp(16'(n), 16'(ncyc));
        if (n == 8) tally_and_finish();
    endtask : issue

    task automatic shift(input dtb_op_t op, input int rd);
        logic [7:0] x;
        logic [8:0] cr;
        x = 8'(gpr[rd]);
        case (op)
            OP_SHIFT_LEFT_LOGICAL: cr = {x, 1'b0};
            OP_SHIFT_RIGHT_LOGICAL: cr = {x[0], 1'b0, x[7:1]};
            OP_ROTATE_LEFT_CARRY: cr = {x, flg[0]};
            OP_ROTATE_RIGHT_CARRY: cr = {x[0], flg[0], x[7:1]};
            OP_SHIFT_RIGHT_ARITH: cr = {x[0], x[7], x[7:1]};
            default: cr = {1'b0, x[3:0], x[7:4]};
        endcase
        gpr[rd] = cr[7:0];
        if (op != OP_NIBBLE_SWAP) flg = (flg & 'hf0) | {cr[7] ^ cr[8], cr[7], cr[7:0] == 0, cr[8]};
        issue(op, rd, 0, 0, 0, 1);
        chk(rd);
        reg_rd(8'h20, flg);
    endtask : shift

    initial begin
        repeat (100000) @(posedge clk_sys);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        int v, z;
        {sys_rst, cmd_valid, reg_we, reg_re} = 4'h8;
        cmd = '0;
        {reg_addr, reg_wdata} = 16'h0000;
        {fail_count, checks_done, flg, sp} = '0;
        foreach (gpr[i]) gpr[i] = 0;
        void'($urandom(32'hcf62ca09));
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        reg_rd(8'h20, 0);
        reg_rd(8'h21, 0);
        reg_rd(8'h30, 0);
        reg_wr(8'h23, 8'hff);
        reg_rd(8'h23, 0);
        for (int i = 0; i < 4; i++) begin
            for (int k = 8; k < 14; k++) begin
                setr(k + 2, (i == 0) ? 'h80 : $urandom);
                flg = $urandom & 255;
                reg_wr(8'h20, 8'(flg));
                shift(dtb_op_t'(k), k + 2);
            end
        end
        for (int s = 0; s < 8; s++) begin
            flg = flg | (1 << s);
            issue(OP_STATUS_BIT_SET, 0, 0, 0, s, 1);
            reg_rd(8'h20, flg);
            flg = flg & ~(1 << s);
            issue(OP_STATUS_BIT_CLEAR, 0, 0, 0, s, 1);
            reg_rd(8'h20, flg);
            setr(5, $urandom);
            flg = (flg & 'hbf) | (((gpr[5] >> s) & 1) << 6);
            issue(OP_BIT_TO_FLAG_STORE, 0, 5, 0, s, 1);
            reg_rd(8'h20, flg);
        end
        v = $urandom & 255;
        u_mem.io_mem[5] = 8'(v);
        gpr[3] = v;
        issue(OP_PORT_IN, 3, 0, 5, 0, 1);
        chk(3);
        issue(OP_PORT_OUT, 0, 3, 9, 0, 1);
        @(posedge clk_sys);
        #1;
        cmp(16'(u_mem.io_mem[9]), 16'(v));
        iov = v;
        for (int b = 0; b < 8; b++) begin
            iov = iov | (1 << b);
            issue(OP_IO_BIT_SET, 0, 0, 9, b, 2);
            cmp(16'(u_mem.io_mem[9]), 16'(iov));
            iov = iov & ~(1 << (7 - b));
            issue(OP_IO_BIT_CLEAR, 0, 0, 9, 7 - b, 2);
            cmp(16'(u_mem.io_mem[9]), 16'(iov));
        end
        reg_wr(8'h21, 8'h40);
        reg_wr(8'h22, 8'h01);
        sp = 'h13f;
        issue(OP_STACK_PUSH, 0, 3, 0, 0, 2);
        cmp(16'(u_mem.st_mem[8'h40]), 16'(gpr[3]));
        reg_rd(8'h21, sp);
        reg_rd(8'h22, sp >> 8);
        issue(OP_STACK_POP, 7, 0, 0, 0, 2);
        gpr[7] = gpr[3];
        chk(7);
        reg_rd(8'h21, sp + 1);
        z = $urandom_range(255, 0);
        setr(30, z);
        setr(31, 0);
        v = $urandom & 'hffff;
        u_mem.pm_mem[z >> 1] = 16'(v);
        u_mem.pm_mem[(z >> 1) + 1] = 16'(~v);
        for (int i = 0; i < 2; i++) begin
            issue(OP_PROGRAM_MEM_READ_INC, 4, 0, 0, 0, 3);
            gpr[4] = (((i > 0 && !(z & 1)) ? ~v : v) >> (8 * (z & 1))) & 255;
            z++;
            gpr[30] = z & 255;
            gpr[31] = z >> 8;
            chk(4);
            chk(30);
            chk(31);
        end
        setr(0, $urandom);
        setr(1, $urandom);
        issue(OP_PROGRAM_MEM_WRITE, 0, 0, 0, 0, 2);
        cmp(u_mem.pm_mem[z >> 1], 16'(gpr[1] * 256 + gpr[0]));
        reg_rd(8'h20, flg);
        tally_and_finish();
    end
endmodule : tb

bind dtb_exec dtb_exec_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .done(done),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .pm_req(pm_req), .pm_rdata(pm_rdata), .io_raddr(io_raddr),
    .io_rdata(io_rdata), .io_req(io_req), .st_req(st_req), .st_rdata(st_rdata));
